// >>> design/region_attr_map.sv
// Purpose: per-region attribute store and access qualification
// Assumes: one fetch and one load/store lookup each cycle
// Notes: attributes written by a simple config port
`timescale 1ns/10ps
`default_nettype none
`include "region_attr_cfg.svh"
module region_attr_map (
  input wire logic ref_clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic attr_we, // write one region's attributes
  input wire logic [`REGION_IDX_W-1:0] attr_region, // region to write
  input wire logic attr_cacheable, // new cacheable value
  input wire logic attr_side_effect, // new side-effect value
  input wire logic attr_rom, // region holds a system rom
  input wire logic [`REGION_IDX_W-1:0] lmem_region, // local memory region
  input wire logic [`LMEM_KB_W-1:0] instr_lmem_kb, // instr memory size
  input wire logic [`LMEM_KB_W-1:0] data_lmem_kb, // data memory size
  input wire logic fetch_valid, // fetch lookup
  input wire logic fetch_spec, // fetch is speculative
  input wire logic [`ADDR_W-1:0] fetch_addr, // fetch address
  input wire logic ls_valid, // load/store lookup
  input wire logic ls_store, // access is a store
  input wire logic ls_spec, // access is speculative
  input wire logic [`ADDR_W-1:0] ls_addr, // load/store address
  output logic fetch_cache_ok, // fetch may be cached
  output logic fetch_issue_ok, // fetch may go out now
  output logic fetch_local, // fetch hits local memory region
  output logic fetch_rom, // fetch hits system rom
  output logic ls_cache_ok, // access may be cached
  output logic ls_issue_ok, // access may go out now
  output logic ls_merge_ok, // store may merge
  output logic ls_local, // access hits local memory region
  output logic ls_rom, // access hits system rom
  output logic attr_illegal, // illegal pair was refused
  output logic map_conflict, // rom or cacheable mapped in local region
  output logic size_bad // local memory size not legal
);
  logic rst_meta;
  logic rst_n;
  logic [`REGION_CNT-1:0] cache_map;
  logic [`REGION_CNT-1:0] side_map;
  logic [`REGION_CNT-1:0] rom_map;
  logic [`REGION_IDX_W-1:0] lmem_reg;
  logic next_illegal;
  logic next_conflict;
  logic instr_size_ok;
  logic data_size_ok;
  logic next_fetch_local;
  logic next_ls_local;
  region_attr_pkg::attr_t next_attr;
  region_lookup_if fetch_if ();
  region_lookup_if ls_if ();

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign next_attr = {attr_cacheable, attr_side_effect};

  // refuse illegal pair
  // Refused whole, so a stray pair never half lands
  assign next_illegal = attr_we & next_attr.cacheable & next_attr.side_effect;

  // cacheable kept apart from side effect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_map <= '0;
    end else if (attr_we && !next_illegal) begin
      cache_map[attr_region] <= next_attr.cacheable;
    end
  end

  // side effect in its own store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      side_map <= '0;
    end else if (attr_we && !next_illegal) begin
      side_map[attr_region] <= next_attr.side_effect;
    end
  end

  // rom regions serve fetch and data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_map <= '0;
    end else if (attr_we && !next_illegal) begin
      rom_map[attr_region] <= attr_rom;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      attr_illegal <= 1'b0;
    end else if (attr_we) begin
      attr_illegal <= next_illegal;
    end
  end

  // Local region sampled every cycle after reset release, not under reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lmem_reg <= `LMEM_REGION_DEF;
    end else begin
      lmem_reg <= lmem_region;
    end
  end

  // flag mixed classes
  // Cacheable there means bus memory shares the region
  always_comb begin
    next_conflict = rom_map[lmem_reg] | cache_map[lmem_reg];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_conflict <= 1'b0;
    end else begin
      map_conflict <= next_conflict;
    end
  end

  // Range and power of two, plus the data-only odd size
  function automatic logic size_legal(input logic [`LMEM_KB_W-1:0] kb, input logic data_side);
    logic in_range;
    logic pow2;
    logic ok;
    in_range = (kb >= `LMEM_KB_W'(`LMEM_KB_MIN)) && (kb <= `LMEM_KB_W'(`LMEM_KB_MAX));
    pow2 = ((kb & (kb - `LMEM_KB_W'(1))) == '0);
    ok = in_range && pow2;
    if (data_side && kb == `LMEM_KB_W'(`LMEM_KB_DATA_ONLY)) begin
      ok = 1'b1;
    end
    size_legal = ok;
  endfunction

  // build-time size check
  // Sizes are straps, so a bad one only raises a flag
  assign instr_size_ok = size_legal(instr_lmem_kb, 1'b0);
  assign data_size_ok = size_legal(data_lmem_kb, 1'b1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      size_bad <= 1'b0;
    end else begin
      size_bad <= !instr_size_ok || !data_size_ok;
    end
  end

  assign fetch_if.valid = fetch_valid;
  // Fetches never store, so they never merge
  assign fetch_if.is_store = 1'b0;
  assign fetch_if.speculative = fetch_spec;
  assign fetch_if.addr = fetch_addr;
  assign ls_if.valid = ls_valid;
  assign ls_if.is_store = ls_store;
  assign ls_if.speculative = ls_spec;
  assign ls_if.addr = ls_addr;

  // Two copies: fetch and load/store look up in one cycle
  region_lookup u_fetch (
    .lk(fetch_if),
    .cache_map(cache_map),
    .side_map(side_map),
    .rom_map(rom_map)
  );

  region_lookup u_ls (
    .lk(ls_if),
    .cache_map(cache_map),
    .side_map(side_map),
    .rom_map(rom_map)
  );

  // local hit against the registered local region
  assign next_fetch_local = fetch_valid & (fetch_if.region == lmem_reg);
  assign next_ls_local = ls_valid & (ls_if.region == lmem_reg);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_cache_ok <= 1'b0;
      fetch_issue_ok <= 1'b0;
      fetch_local <= 1'b0;
      fetch_rom <= 1'b0;
    end else begin
      fetch_cache_ok <= fetch_if.cache_ok;
      fetch_issue_ok <= fetch_if.issue_ok;
      fetch_local <= next_fetch_local;
      fetch_rom <= fetch_if.rom_hit;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_cache_ok <= 1'b0;
      ls_issue_ok <= 1'b0;
      ls_merge_ok <= 1'b0;
      ls_local <= 1'b0;
      ls_rom <= 1'b0;
    end else begin
      ls_cache_ok <= ls_if.cache_ok;
      ls_issue_ok <= ls_if.issue_ok;
      ls_merge_ok <= ls_if.merge_ok;
      ls_local <= next_ls_local;
      ls_rom <= ls_if.rom_hit;
    end
  end
endmodule
`default_nettype wire

// >>> design/region_attr_cfg.svh
// Purpose: constants for the address-region attribute map
// Assumes: 32-bit addresses, sixteen regions
// Notes: values are fixed, not parameters
`ifndef REGION_ATTR_CFG_SVH
`define REGION_ATTR_CFG_SVH
`define ADDR_W 32
`define REGION_CNT 16
`define REGION_IDX_W 4
`define REGION_IDX_HI 31
`define REGION_IDX_LO 28
`define REGION_SIZE_MB 256
`define LMEM_KB_MIN 4
`define LMEM_KB_MAX 512
`define LMEM_KB_DATA_ONLY 48
`define LMEM_KB_W 10
`define ATTR_RESET 2'h0
`define ATTR_CACHE_BIT 1
`define ATTR_SIDE_BIT 0
`define INSTR_LMEM_KB_DEF 10'h040
`define DATA_LMEM_KB_DEF 10'h030
`define LMEM_REGION_DEF 4'hF
`endif

// >>> design/region_attr_pkg.sv
// Purpose: types for the address-region attribute map
// Assumes: region_attr_cfg.svh supplies the numbers
// Notes: types only
`include "region_attr_cfg.svh"
package region_attr_pkg;
  typedef struct packed {
    logic cacheable;
    logic side_effect;
  } attr_t;
  typedef enum logic [1:0] {
    mem_local,
    mem_rom,
    mem_ram,
    mem_io
  } mem_class_t;
  typedef enum {
    cfg_idle,
    cfg_load,
    cfg_run
  } cfg_state_t;
endpackage

// >>> design/region_lookup_if.sv
// Purpose: carries one access lookup between top and lookup unit
// Assumes: single clock
// Notes: modports for the requester and the lookup unit
`timescale 1ns/10ps
`default_nettype none
`include "region_attr_cfg.svh"
interface region_lookup_if;
  logic valid;
  logic is_store;
  logic speculative;
  logic [`ADDR_W-1:0] addr;
  logic [`REGION_IDX_W-1:0] region;
  logic cache_ok;
  logic issue_ok;
  logic merge_ok;
  logic rom_hit;
  modport req (output valid, is_store, speculative, addr,
    input region, cache_ok, issue_ok, merge_ok, rom_hit);
  modport unit (input valid, is_store, speculative, addr,
    output region, cache_ok, issue_ok, merge_ok, rom_hit);
endinterface
`default_nettype wire

// >>> design/region_lookup.sv
// Purpose: decodes an access address to its region's permissions
// Assumes: attribute vectors stable while looked up
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "region_attr_cfg.svh"
module region_lookup (
  region_lookup_if.unit lk, // lookup request and answer
  input wire logic [`REGION_CNT-1:0] cache_map, // cacheable per region
  input wire logic [`REGION_CNT-1:0] side_map, // side effect per region
  input wire logic [`REGION_CNT-1:0] rom_map // system rom per region
);
  logic cache_bit;
  logic side_bit;
  assign lk.region = lk.addr[`REGION_IDX_HI:`REGION_IDX_LO];
  assign cache_bit = cache_map[lk.region];
  assign side_bit = side_map[lk.region];
  assign lk.cache_ok = lk.valid & cache_bit & ~side_bit;
  assign lk.issue_ok = lk.valid & ~(side_bit & lk.speculative);
  assign lk.merge_ok = lk.valid & lk.is_store & ~side_bit;
  assign lk.rom_hit = lk.valid & rom_map[lk.region];
endmodule
`default_nettype wire

// >>> sim/core_access_model.sv
// Purpose: fetch and load/store units issuing lookups
// Assumes: bench supplies one random word per cycle
// Notes: requests change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
`include "region_attr_cfg.svh"
module core_access_model (
  input wire logic ref_clk, // core clock
  input wire logic en, // issue requests
  input wire logic [`ADDR_W-1:0] rnd, // random word
  output logic fetch_valid, // fetch lookup
  output logic fetch_spec, // speculative fetch
  output logic [`ADDR_W-1:0] fetch_addr, // fetch address
  output logic ls_valid, // load/store lookup
  output logic ls_store, // is a store
  output logic ls_spec, // speculative access
  output logic [`ADDR_W-1:0] ls_addr // load/store address
);
  always @(negedge ref_clk) begin
    {ls_spec, ls_store, ls_valid, fetch_spec, fetch_valid} <= en ? rnd[4:0] : 5'h00;
    fetch_addr <= rnd;
    ls_addr <= {rnd[11:8], rnd[31:4]};
  end
endmodule
`default_nettype wire

// >>> sim/region_attr_map_assertions.sv
// Purpose: timing relations at the attribute map ports
// Assumes: answers one cycle after the request
// Notes: bound into every instance of the map
`timescale 1ns/10ps
`default_nettype none
`include "region_attr_cfg.svh"
module region_attr_map_assertions (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic attr_we, // write
  input wire logic [`REGION_IDX_W-1:0] attr_region, // region
  input wire logic attr_cacheable, // cacheable
  input wire logic attr_side_effect, // side effect
  input wire logic fetch_valid, // fetch
  input wire logic fetch_spec, // fetch spec
  input wire logic fetch_cache_ok, // fetch cache
  input wire logic fetch_issue_ok, // fetch issue
  input wire logic fetch_rom, // fetch rom
  input wire logic ls_valid, // access
  input wire logic ls_store, // store
  input wire logic ls_spec, // access spec
  input wire logic [`ADDR_W-1:0] ls_addr, // address
  input wire logic ls_cache_ok, // access cache
  input wire logic ls_issue_ok, // access issue
  input wire logic ls_merge_ok, // merge
  input wire logic attr_illegal // refused
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  fetch_nonspec_a: assert property (fetch_valid && !fetch_spec |=> fetch_issue_ok)
    else $error("nonspeculative fetch held back");
  ls_nonspec_a: assert property (ls_valid && !ls_spec |=> ls_issue_ok)
    else $error("nonspeculative access held back");
  merge_store_a: assert property (ls_merge_ok |-> $past(ls_valid && ls_store))
    else $error("merge without a store");
  fetch_idle_a: assert property (!fetch_valid |=> !fetch_cache_ok && !fetch_issue_ok)
    else $error("fetch answer without request");
  cache_issue_a: assert property (ls_cache_ok |-> ls_issue_ok)
    else $error("cacheable access not issued");
  illegal_set_a: assert property (attr_we && attr_cacheable && attr_side_effect |=> attr_illegal)
    else $error("illegal pair not flagged");
  illegal_hold_a: assert property (!attr_we |=> $stable(attr_illegal))
    else $error("illegal flag moved without write");
  write_cache_a: assert property (attr_we && attr_cacheable && !attr_side_effect ##1
    ls_valid && ls_addr[31:28] == $past(attr_region) |=> ls_cache_ok)
    else $error("new cacheable region not cached");
  cover property (attr_we && attr_cacheable && attr_side_effect);
  cover property (ls_merge_ok);
  cover property (fetch_rom);
endmodule
bind region_attr_map region_attr_map_assertions chk (.*);
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: random lookups and writes against a bench model
// Assumes: answers one cycle after the request
// Notes: the design sees the local region one cycle late
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, nrst = 0, en = 0, attr_we = 0, attr_cacheable = 0;
  logic attr_side_effect = 0, attr_rom = 0;
  logic [3:0] attr_region = 4'h0, lmem_region = 4'hF;
  logic [9:0] instr_lmem_kb = 10'h040, data_lmem_kb = 10'h030;
  logic [31:0] rnd = 32'h0, fetch_addr, ls_addr, w;
  logic fetch_valid, fetch_spec, ls_valid, ls_store, ls_spec;
  logic fetch_cache_ok, fetch_issue_ok, fetch_local, fetch_rom, ls_cache_ok, ls_issue_ok;
  logic ls_merge_ok, ls_local, ls_rom, attr_illegal, map_conflict, size_bad;
  logic [11:0] got, exp;
  logic [3:0] fr, lr, lq = 4'hF;
  bit c[16], s[16], r[16], ill;
  int err_count = 0, comparisons = 0, cyc = 0;
  int kb[10] = '{4, 8, 16, 32, 48, 64, 128, 256, 512, 5};
  region_attr_map DUT (.*);
  core_access_model acc (.ref_clk(ref_clk), .en(en), .rnd(rnd), .fetch_valid(fetch_valid),
    .fetch_spec(fetch_spec), .fetch_addr(fetch_addr), .ls_valid(ls_valid),
    .ls_store(ls_store), .ls_spec(ls_spec), .ls_addr(ls_addr));
  always #25 ref_clk = ~ref_clk;
  function automatic bit okkb(int k, bit d);
    return k inside {4, 8, 16, 32, 64, 128, 256, 512} || (d && k == 48);
  endfunction
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    w = $urandom(32'h2D63D34E);
    repeat (12) @(negedge ref_clk);
    nrst = 1;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      fr = fetch_addr[31:28];
      lr = ls_addr[31:28];
      exp = 12'h000;
      if (fetch_valid) exp[11:8] = {c[fr] & !s[fr], !(s[fr] & fetch_spec), fr == lq, r[fr]};
      if (ls_valid) exp[7:3] = {c[lr] & !s[lr], !(s[lr] & ls_spec), ls_store & !s[lr],
        lr == lq, r[lr]};
      // conflict is judged before this cycle's write lands
      exp[1:0] = {r[lq] | c[lq], !okkb(instr_lmem_kb, 0) | !okkb(data_lmem_kb, 1)};
      if (attr_we) begin
        ill = attr_cacheable & attr_side_effect;
        if (!ill) {c[attr_region], s[attr_region], r[attr_region]} = {attr_cacheable,
          attr_side_effect, attr_rom};
      end
      exp[2] = ill;
      got = {fetch_cache_ok, fetch_issue_ok, fetch_local, fetch_rom, ls_cache_ok, ls_issue_ok,
        ls_merge_ok, ls_local, ls_rom, attr_illegal, map_conflict, size_bad};
      comparisons++;
      if (got !== exp) begin
        err_count++;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
      lq = lmem_region;
      w = $urandom;
      en <= 1'b1;
      rnd <= $urandom;
      attr_we <= w[1:0] == 2'h0;
      attr_region <= w[5:2];
      {attr_cacheable, attr_side_effect, attr_rom} <= w[8:6];
      // both local memories share one region
      if (w[14:10] == 5'h00) lmem_region <= w[19:16];
      instr_lmem_kb <= 10'(kb[w[23:20] % 10]);
      data_lmem_kb <= 10'(kb[w[27:24] % 10]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
